/* src/pphp_host_port.sv */
`timescale 1ns/1ps
module pphp_host_port
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Host strobes and selects
  input wire logic hostSelectN,
  input wire logic inputStrobeN,
  input wire logic outputStrobeN,
  input wire logic readWriteLine,
  input wire logic singleDataStrobe,
  input wire logic byteSelect,
  input wire logic hostStatusSelect,
  // Host data bus, split per lane
  input wire logic [pphp_pkg::DATA_W-1:0] hostBusIn,
  output logic [pphp_pkg::DATA_W-1:0] hostBusOut,
  output logic [pphp_pkg::LANES-1:0] hostBusOeN,
  // Buffer state pins
  output logic inputFullFlag,
  output logic outputEmptyFlag,
  // Control load from the I/O unit
  input wire logic controlLoad,
  input wire logic [pphp_pkg::DATA_W-1:0] controlData,
  output logic [pphp_pkg::DATA_W-1:0] hostPortControl,
  // Output words from I/O RAM
  input wire logic outWordValid,
  output logic outWordReady,
  input wire logic [pphp_pkg::DATA_W-1:0] outWord,
  // Input words toward I/O RAM
  output logic inWordValid,
  input wire logic inWordReady,
  output logic [pphp_pkg::DATA_W-1:0] inWord
);
  import pphp_pkg::*;

  //==========================================================================
  // Synchronisers
  logic [SYNC_W-1:0] syncRaw, syncMeta, syncLive, next_syncMeta, next_syncLive;

  // Bus data rides with the strobes so both arrive aligned
  assign syncRaw = {hostBusIn, hostStatusSelect, byteSelect, singleDataStrobe,
                    readWriteLine, outputStrobeN, inputStrobeN, hostSelectN};

  always_comb
  begin
    next_syncMeta = syncRaw;
    next_syncLive = syncMeta;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      syncMeta <= SYNC_RESET;
      syncLive <= SYNC_RESET;
    end
    else
    begin
      syncMeta <= next_syncMeta;
      syncLive <= next_syncLive;
    end
  end

  //==========================================================================
  // Strobe decode
  logic selected, dsOn, readReq, writeReq, effSel, ext16, log16, swapBytes;
  logic [DATA_W-1:0] busLive;

  assign busLive = syncLive[SYNC_BUS +: DATA_W];
  assign ext16 = hostPortControl[CTL_EXT_WIDTH];
  assign log16 = hostPortControl[CTL_LOGICAL_WIDTH];
  assign swapBytes = hostPortControl[CTL_LOGICAL_WIDTH];
  // Only the host's own strobes start anything; nothing here drives one
  assign selected = ~syncLive[SYNC_SELN];
  assign dsOn = (syncLive[SYNC_DS] == hostPortControl[CTL_DS_POL]);
  assign effSel = syncLive[SYNC_BSEL] ^ hostPortControl[CTL_BSEL_POL];

  always_comb
  begin
    if (hostPortControl[CTL_PROTOCOL])
    begin
      readReq = selected & dsOn & syncLive[SYNC_RW];
      writeReq = selected & dsOn & ~syncLive[SYNC_RW];
    end
    else
    begin
      readReq = selected & ~syncLive[SYNC_ODSN];
      writeReq = selected & ~syncLive[SYNC_IDSN];
    end
  end

  //==========================================================================
  // Access tracking
  logic readPrev, writePrev, readSel, writeSel, readStat;
  logic next_readPrev, next_writePrev, next_readSel, next_writeSel, next_readStat;
  logic [DATA_W-1:0] writeLatch, next_writeLatch;
  logic readDone, writeDone, readCounts, writeCounts;

  // An access ends when its strobe falls away or select is dropped
  assign readDone = readPrev & ~readReq;
  assign writeDone = writePrev & ~writeReq;

  always_comb
  begin
    next_readPrev = readReq;
    next_writePrev = writeReq;
    next_readSel = readReq ? effSel : readSel;
    next_readStat = readReq ? syncLive[SYNC_STAT] : readStat;
    next_writeSel = writeReq ? effSel : writeSel;
    // Last sample before the strobe ends is the word taken
    next_writeLatch = writeReq ? busLive : writeLatch;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      readPrev <= 1'b0;
      writePrev <= 1'b0;
      readSel <= 1'b0;
      readStat <= 1'b0;
      writeSel <= 1'b0;
      writeLatch <= '0;
    end
    else
    begin
      readPrev <= next_readPrev;
      writePrev <= next_writePrev;
      readSel <= next_readSel;
      readStat <= next_readStat;
      writeSel <= next_writeSel;
      writeLatch <= next_writeLatch;
    end
  end

  // Which completed accesses close a logical word
  always_comb
  begin
    if (ext16)
    begin
      readCounts = ~readStat;
      writeCounts = 1'b1;
    end
    else if (log16)
    begin
      readCounts = ~readStat & (readSel != hostPortControl[CTL_BSEL_POL]);
      writeCounts = (writeSel != hostPortControl[CTL_BSEL_POL]);
    end
    else
    begin
      // Select 1 is reserved in 8-bit logical mode and changes nothing
      readCounts = ~readStat & ~readSel;
      writeCounts = ~writeSel;
    end
  end

  //==========================================================================
  // Control and data buffers
  logic [DATA_W-1:0] next_hostPortControl, inData, next_inData, outData, next_outData;
  logic inputFull, outputEmpty, controlLoaded;
  logic next_inputFull, next_outputEmpty, next_controlLoaded;
  logic bufReady, drainIn, refillOut, writeTaken;

  // Transfers wait until the I/O unit has loaded a control word
  assign outWordReady = outputEmpty & controlLoaded;
  assign refillOut = outWordValid & outWordReady;
  assign drainIn = inputFull & controlLoaded & bufReady;
  assign writeTaken = writeDone & (ext16 | log16 | ~writeSel);

  always_comb
  begin
    next_hostPortControl = controlLoad ? controlData : hostPortControl;
    next_controlLoaded = controlLoaded | controlLoad;
    next_outData = refillOut ? outWord : outData;
    next_inData = inData;
    if (writeTaken)
    begin
      if (ext16)
      begin
        next_inData = swapBytes ? {busLiveByte(writeLatch, 0), busLiveByte(writeLatch, 1)}
                                : writeLatch;
      end
      else if (writeSel)
      begin
        next_inData[DATA_W-1:BYTE_W] = writeLatch[BYTE_W-1:0];
      end
      else
      begin
        next_inData[BYTE_W-1:0] = writeLatch[BYTE_W-1:0];
      end
    end
    // A host event in the same cycle as a drain or refill wins
    next_inputFull = (writeDone & writeCounts) ? 1'b1 : (drainIn ? 1'b0 : inputFull);
    next_outputEmpty = (readDone & readCounts) ? 1'b1 : (refillOut ? 1'b0 : outputEmpty);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      hostPortControl <= CONTROL_RESET;
      controlLoaded <= 1'b0;
      outData <= '0;
      inData <= '0;
      inputFull <= 1'b0;
      outputEmpty <= 1'b1;
    end
    else
    begin
      hostPortControl <= next_hostPortControl;
      controlLoaded <= next_controlLoaded;
      outData <= next_outData;
      inData <= next_inData;
      inputFull <= next_inputFull;
      outputEmpty <= next_outputEmpty;
    end
  end

  function automatic logic [BYTE_W-1:0] busLiveByte(input logic [DATA_W-1:0] word,
                                                    input int lane);
    busLiveByte = word[lane*BYTE_W +: BYTE_W];
  endfunction

  //==========================================================================
  // Input word buffer toward I/O RAM
  pphp_pair_buffer
  #(
    .WIDTH(DATA_W),
    .DEPTH(BUF_DEPTH)
  )
  u_inBuffer
  (
    .clk(clk),
    .reset(reset),
    .fillValid(drainIn),
    .fillReady(bufReady),
    .fillData(inData),
    .drainValid(inWordValid),
    .drainReady(inWordReady),
    .drainData(inWord)
  );

  //==========================================================================
  // Host read lanes and flag pins
  logic [BYTE_W-1:0] statusByte;
  logic [DATA_W-1:0] next_hostBusOut;
  logic [LANES-1:0] next_hostBusOeN;
  logic next_inputFullFlag, next_outputEmptyFlag, mergedFlag;

  always_comb
  begin
    statusByte = ZERO_BYTE;
    statusByte[STAT_FULL_BIT] = inputFull;
    statusByte[STAT_EMPTY_BIT] = outputEmpty ^ hostPortControl[CTL_STATUS_INV];
  end

  always_comb
  begin
    next_hostBusOut = hostBusOut;
    next_hostBusOeN = LANES_OFF;
    if (readReq)
    begin
      if (ext16)
      begin
        next_hostBusOeN = LANES_ON;
        if (syncLive[SYNC_STAT])
        begin
          next_hostBusOut = swapBytes ? {statusByte, ZERO_BYTE} : {ZERO_BYTE, statusByte};
        end
        else
        begin
          next_hostBusOut = swapBytes ? {outData[BYTE_W-1:0], outData[DATA_W-1:BYTE_W]}
                                      : outData;
        end
      end
      else if (log16 | ~effSel)
      begin
        next_hostBusOeN = LANE_LOW_ON;
        next_hostBusOut[DATA_W-1:BYTE_W] = ZERO_BYTE;
        if (syncLive[SYNC_STAT])
        begin
          next_hostBusOut[BYTE_W-1:0] = statusByte;
        end
        else if (effSel)
        begin
          next_hostBusOut[BYTE_W-1:0] = outData[DATA_W-1:BYTE_W];
        end
        else
        begin
          next_hostBusOut[BYTE_W-1:0] = outData[BYTE_W-1:0];
        end
      end
      else
      begin
        // Reserved combination: lanes stay off rather than guess
        next_hostBusOeN = LANES_OFF;
      end
    end
    mergedFlag = inputFull | outputEmpty;
    if (hostPortControl[CTL_FLAG_MERGE])
    begin
      next_inputFullFlag = mergedFlag;
    end
    else
    begin
      next_inputFullFlag = inputFull ^ hostPortControl[CTL_FLAG_POL];
    end
    next_outputEmptyFlag = outputEmpty ^ hostPortControl[CTL_FLAG_POL];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      hostBusOut <= '0;
      hostBusOeN <= LANES_OFF;
      inputFullFlag <= 1'b0;
      outputEmptyFlag <= 1'b1;
    end
    else
    begin
      hostBusOut <= next_hostBusOut;
      hostBusOeN <= next_hostBusOeN;
      inputFullFlag <= next_inputFullFlag;
      outputEmptyFlag <= next_outputEmptyFlag;
    end
  end
endmodule // pphp_host_port

/* src/pphp_pair_buffer.sv */
`timescale 1ns/1ps
module pphp_pair_buffer
#(
  parameter int unsigned WIDTH = pphp_pkg::DATA_W,
  parameter int unsigned DEPTH = pphp_pkg::BUF_DEPTH
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Fill side
  input wire logic fillValid,
  output logic fillReady,
  input wire logic [WIDTH-1:0] fillData,
  // Drain side
  output logic drainValid,
  input wire logic drainReady,
  output logic [WIDTH-1:0] drainData
);
  import pphp_pkg::*;
  localparam int unsigned PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] entry [DEPTH];
  logic [WIDTH-1:0] next_entry [DEPTH];
  logic [PTR_W-1:0] wrPtr, next_wrPtr, rdPtr, next_rdPtr;
  logic [PTR_W:0] count, next_count;
  logic push, pop;

  assign fillReady = (count != DEPTH[PTR_W:0]);
  assign drainValid = (count != '0);
  assign drainData = entry[rdPtr];
  assign push = fillValid & fillReady;
  assign pop = drainValid & drainReady;

  //==========================================================================
  // Storage
  always_comb
  begin
    next_entry = entry;
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    next_count = count;
    if (push)
    begin
      next_entry[wrPtr] = fillData;
      next_wrPtr = (wrPtr == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(wrPtr + 1'b1);
    end
    if (pop)
    begin
      next_rdPtr = (rdPtr == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(rdPtr + 1'b1);
    end
    // Simultaneous push and pop keep the count
    if (push && !pop)
    begin
      next_count = (PTR_W + 1)'(count + 1'b1);
    end
    else if (pop && !push)
    begin
      next_count = (PTR_W + 1)'(count - 1'b1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      for (int i = 0; i < DEPTH; i++)
      begin
        entry[i] <= '0;
      end
    end
    else
    begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
      entry <= next_entry;
    end
  end
endmodule // pphp_pair_buffer

/* src/pphp_pkg.sv */
//==============================================================================
// Contract
// - Port is passive; the host makes every strobe, the device never does.
// - Narrow external bus carries byte data in the low bit positions.
// - Strobes count only while host select is low; tie low for continuous use.
// - Recognised host request refills output buffer or drains input buffer once programmed.
// - Wide external bus sets full/empty after every completed transaction; status reads set neither.
// - Narrow bus: control bit 0 set means 16-bit logical, clear 8-bit.
// - Effective byte select is the pin XOR control bit 3.
// - Narrow 16-bit logical: flags after high byte if polarity 0, low byte if 1.
// - Narrow 8-bit logical: low byte only, flag on every completed access; status reads and select 1 accesses set no flag.
// - Control bit 1 picks separate strobes or one strobe plus read/write line.
// - Separate strobes active low; single strobe level set by control bit 2.
// - Control bit 4 sets flag pin levels; active high when the bit is low.
// - Control bit 5 puts the active-high OR of both flags on input-full pin.
// - Control bit 6 inverts empty bit in status byte only, not the pin.
// - Host reads the status byte only while status select is asserted.
// - Narrow reads: upper lane off; low lane status, low byte or high byte.
// - Wide reads: full word, swapped when bit 0 set; status with zero byte.
// - Narrow writes load low byte or, in 16-bit logical, high byte; other kept.
// - Wide writes load the full word, swapped when bit 0 set.
// - Output buffer loads from I/O unit word; input buffer loads from host bus.
// - Device drives input-full and output-empty pins showing buffer state.
//==============================================================================
package pphp_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned LANES = 2;
  // Control register fields
  localparam int unsigned CTL_LOGICAL_WIDTH = 0;
  localparam int unsigned CTL_PROTOCOL = 1;
  localparam int unsigned CTL_DS_POL = 2;
  localparam int unsigned CTL_BSEL_POL = 3;
  localparam int unsigned CTL_FLAG_POL = 4;
  localparam int unsigned CTL_FLAG_MERGE = 5;
  localparam int unsigned CTL_STATUS_INV = 6;
  localparam int unsigned CTL_EXT_WIDTH = 7;
  localparam logic [DATA_W-1:0] CONTROL_RESET = 16'h0000;
  // Status byte fields
  localparam int unsigned STAT_FULL_BIT = 0;
  localparam int unsigned STAT_EMPTY_BIT = 1;
  localparam logic [BYTE_W-1:0] ZERO_BYTE = 8'h00;
  // Lane enables, active low
  localparam logic [LANES-1:0] LANES_OFF = 2'h3;
  localparam logic [LANES-1:0] LANE_LOW_ON = 2'h2;
  localparam logic [LANES-1:0] LANES_ON = 2'h0;
  // Synchroniser vector layout
  localparam int unsigned SYNC_SELN = 0;
  localparam int unsigned SYNC_IDSN = 1;
  localparam int unsigned SYNC_ODSN = 2;
  localparam int unsigned SYNC_RW = 3;
  localparam int unsigned SYNC_DS = 4;
  localparam int unsigned SYNC_BSEL = 5;
  localparam int unsigned SYNC_STAT = 6;
  localparam int unsigned SYNC_BUS = 7;
  localparam int unsigned SYNC_W = SYNC_BUS + DATA_W;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 23'h000007;
  // Input path buffer
  localparam int unsigned BUF_DEPTH = 2;
endpackage

/* testbench/pphp_asserts.sv */
`timescale 1ns/1ps
module pphp_asserts
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Host pins
  input wire logic hostSelectN,
  input wire logic outputStrobeN,
  input wire logic hostStatusSelect,
  input wire logic [pphp_pkg::DATA_W-1:0] hostBusOut,
  input wire logic [pphp_pkg::LANES-1:0] hostBusOeN,
  input wire logic inputFullFlag,
  input wire logic outputEmptyFlag,
  // I/O unit side
  input wire logic controlLoad,
  input wire logic [pphp_pkg::DATA_W-1:0] controlData,
  input wire logic [pphp_pkg::DATA_W-1:0] hostPortControl,
  input wire logic outWordValid,
  input wire logic outWordReady,
  input wire logic inWordValid,
  input wire logic inWordReady,
  input wire logic [pphp_pkg::DATA_W-1:0] inWord
);
  import pphp_pkg::*;
  //==========================================================================
  // Properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  property p_ctl_load;
    controlLoad |=> hostPortControl == $past(controlData);
  endproperty
  a_ctl_load: assert property (p_ctl_load)
    else $error("control word not taken");
  // Six cycles cover the two-flop sync plus the output register, with margin
  property p_sel_ignore;
    hostSelectN [*6] |-> hostBusOeN == LANES_OFF;
  endproperty
  a_sel_ignore: assert property (p_sel_ignore)
    else $error("lanes driven without select");
  property p_upper_off;
    !hostPortControl[CTL_EXT_WIDTH] && $stable(hostPortControl) |-> hostBusOeN[1];
  endproperty
  a_upper_off: assert property (p_upper_off)
    else $error("upper lane driven on narrow bus");
  property p_read_lanes;
    (!hostSelectN && !outputStrobeN && hostPortControl[CTL_EXT_WIDTH]
      && !hostPortControl[CTL_PROTOCOL]) [*5] |-> hostBusOeN == LANES_ON;
  endproperty
  a_read_lanes: assert property (p_read_lanes)
    else $error("wide read not driving both lanes");
  property p_status_zero;
    (!hostSelectN && !outputStrobeN && hostStatusSelect && hostPortControl[CTL_EXT_WIDTH]
      && !hostPortControl[CTL_LOGICAL_WIDTH]) [*5] |-> hostBusOut[15:8] == ZERO_BYTE;
  endproperty
  a_status_zero: assert property (p_status_zero)
    else $error("status upper byte not zero");
  property p_in_hold;
    inWordValid && !inWordReady |=> inWordValid && $stable(inWord);
  endproperty
  a_in_hold: assert property (p_in_hold)
    else $error("input word dropped while stalled");
  property p_refill;
    outWordValid && outWordReady |-> ##2 outputEmptyFlag == hostPortControl[CTL_FLAG_POL];
  endproperty
  a_refill: assert property (p_refill)
    else $error("empty pin wrong after refill");
  property p_merge;
    hostPortControl[CTL_FLAG_MERGE] && $stable(hostPortControl)
      && (outputEmptyFlag != hostPortControl[CTL_FLAG_POL]) |-> inputFullFlag;
  endproperty
  a_merge: assert property (p_merge)
    else $error("merged flag missing empty");
  // A strobe edge must not reach the lanes in the cycle after it is sampled
  property p_sync_delay;
    $fell(outputStrobeN) |=> hostBusOeN == LANES_OFF;
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("read lanes driven before strobe synchronised");
endmodule // pphp_asserts

bind pphp_host_port pphp_asserts u_pphp_asserts (.*);

/* testbench/pphp_host_model.sv */
`timescale 1ns/1ps
module pphp_host_model
(
  // Clock and port setup
  input wire logic clk,
  input wire logic [15:0] hostPortControl,
  // Host pins
  output logic hostSelectN,
  output logic inputStrobeN,
  output logic outputStrobeN,
  output logic readWriteLine,
  output logic singleDataStrobe,
  output logic byteSelect,
  output logic hostStatusSelect,
  output logic [15:0] hostBusIn,
  input wire logic [15:0] hostBusOut,
  input wire logic [1:0] hostBusOeN
);
  initial
  begin
    hostSelectN = 1'b1;
    inputStrobeN = 1'b1;
    outputStrobeN = 1'b1;
    readWriteLine = 1'b1;
    singleDataStrobe = 1'b1;
    byteSelect = 1'b0;
    hostStatusSelect = 1'b0;
    hostBusIn = 16'h0000;
  end
  //==========================================================================
  // One host access; every strobe comes from this side
  task automatic xfer(input logic c, r, b, s, input logic [15:0] d,
    output logic [15:0] q, output logic [1:0] oe);
    @(negedge clk);
    singleDataStrobe = ~hostPortControl[2];
    repeat (3) @(negedge clk);
    hostSelectN = ~c;
    byteSelect = b;
    hostStatusSelect = s;
    readWriteLine = r;
    hostBusIn = r ? ~hostBusIn : d;
    if (hostPortControl[1])
      singleDataStrobe = hostPortControl[2];
    else if (r)
      outputStrobeN = 1'b0;
    else
      inputStrobeN = 1'b0;
    // Held past the two-flop sync
    repeat (6) @(negedge clk);
    q = hostBusOut;
    oe = hostBusOeN;
    inputStrobeN = 1'b1;
    outputStrobeN = 1'b1;
    singleDataStrobe = ~hostPortControl[2];
    hostSelectN = 1'b1;
    // Released bus must not look like the last word
    hostBusIn = ~hostBusIn;
    repeat (7) @(negedge clk);
  endtask
endmodule // pphp_host_model

/* testbench/tb_passive_parallel_host_port.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_passive_parallel_host_port;
  import pphp_pkg::*;
  logic clk, reset, controlLoad, outWordValid, outWordReady, inWordValid, inWordReady;
  logic hostSelectN, inputStrobeN, outputStrobeN, readWriteLine, singleDataStrobe;
  logic byteSelect, hostStatusSelect, inputFullFlag, outputEmptyFlag;
  logic [15:0] hostBusIn, hostBusOut, controlData, hostPortControl, outWord, inWord, q;
  logic [1:0] hostBusOeN, oe;
  int n_checks = 0;
  int n_mismatch = 0;
  int cyc = 0;
  pphp_host_port u_pphp_host_port (.*);
  pphp_host_model u_pphp_host_model (.*);
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  //==========================================================================
  // Helpers
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic hx(input logic c, r, b, s, input logic [15:0] d);
    u_pphp_host_model.xfer(c, r, b, s, d, q, oe);
  endtask
  task automatic ld(input logic [15:0] c);
    @(negedge clk);
    controlLoad = 1'b1;
    controlData = c;
    @(negedge clk);
    controlLoad = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic offer(input logic [15:0] w);
    int n;
    n = 0;
    @(negedge clk);
    outWordValid = 1'b1;
    outWord = w;
    @(posedge clk);
    while (outWordReady !== 1'b1 && n < 30)
    begin
      n++;
      @(posedge clk);
    end
    `CHK(outWordReady, 1'b1)
    @(negedge clk);
    outWordValid = 1'b0;
    outWord = ~w;
  endtask
  task automatic pull(input logic [15:0] e);
    int n;
    n = 0;
    @(negedge clk);
    inWordReady = 1'b1;
    @(posedge clk);
    while (inWordValid !== 1'b1 && n < 30)
    begin
      n++;
      @(posedge clk);
    end
    `CHK(inWordValid, 1'b1)
    `CHK(inWord, e)
    @(negedge clk);
    inWordReady = 1'b0;
  endtask
  //==========================================================================
  // Scenarios
  task automatic t_wide;
    `CHK(hostPortControl, CONTROL_RESET)
    `CHK(outputEmptyFlag, 1'b1)
    `CHK(outWordReady, 1'b0)
    ld(16'h0080);
    offer(16'h1234);
    hx(1, 1, 0, 0, 0);
    `CHK(q, 16'h1234)
    `CHK(outputEmptyFlag, 1'b1)
    hx(1, 1, 0, 1, 0);
    `CHK(q, 16'h0002)
    ld(16'h0081);
    offer(16'habcd);
    hx(1, 1, 0, 0, 0);
    `CHK(q, 16'hcdab)
    hx(1, 0, 0, 0, 16'h5566);
    pull(16'h6655);
    $display("t_wide done");
  endtask
  task automatic t_flags;
    ld(16'h0090);
    `CHK(inputFullFlag, 1'b1)
    `CHK(outputEmptyFlag, 1'b0)
    ld(16'h00a0);
    `CHK(inputFullFlag, 1'b1)
    ld(16'h00c0);
    hx(1, 1, 0, 1, 0);
    `CHK(q, 16'h0000)
    `CHK(outputEmptyFlag, 1'b1)
    $display("t_flags done");
  endtask
  task automatic t_narrow;
    ld(16'h0001);
    offer(16'ha1b2);
    hx(1, 1, 0, 0, 0);
    `CHK(q[7:0], 8'hb2)
    `CHK(oe, LANE_LOW_ON)
    `CHK(outputEmptyFlag, 1'b0)
    hx(1, 1, 1, 0, 0);
    `CHK(q[7:0], 8'ha1)
    `CHK(outputEmptyFlag, 1'b1)
    hx(1, 0, 0, 0, 16'hff34);
    `CHK(inWordValid, 1'b0)
    hx(1, 0, 1, 0, 16'hee12);
    pull(16'h1234);
    hx(1, 1, 1, 1, 0);
    `CHK(q[7:0], 8'h02)
    ld(16'h0009);
    offer(16'hc3d4);
    hx(1, 1, 0, 0, 0);
    `CHK(q[7:0], 8'hc3)
    hx(1, 1, 1, 0, 0);
    `CHK(q[7:0], 8'hd4)
    hx(1, 0, 0, 0, 16'h0056);
    hx(1, 0, 1, 0, 16'h0078);
    pull(16'h5678);
    ld(16'h0000);
    offer(16'h9a5b);
    hx(1, 1, 1, 0, 0);
    `CHK(oe, LANES_OFF)
    hx(1, 1, 0, 0, 0);
    `CHK(q[7:0], 8'h5b)
    `CHK(outputEmptyFlag, 1'b1)
    hx(1, 0, 1, 0, 16'h0011);
    `CHK(inWordValid, 1'b0)
    hx(1, 0, 0, 0, 16'h0077);
    pull(16'h5677);
    $display("t_narrow done");
  endtask
  task automatic t_strobe;
    logic [15:0] m [2] = '{16'h0082, 16'h0086};
    for (int i = 0; i < 2; i++)
    begin
      ld(m[i]);
      offer(m[i] ^ 16'h5a5a);
      hx(1, 1, 0, 0, 0);
      `CHK(q, m[i] ^ 16'h5a5a)
      hx(1, 0, 0, 0, ~m[i]);
      pull(~m[i]);
    end
    $display("t_strobe done");
  endtask
  task automatic t_select;
    ld(16'h0080);
    offer(16'h4242);
    hx(0, 0, 0, 0, 16'h3c3c);
    `CHK(inWordValid, 1'b0)
    hx(0, 1, 0, 0, 0);
    `CHK(oe, LANES_OFF)
    `CHK(outputEmptyFlag, 1'b0)
    $display("t_select done");
  endtask
  // Receiver stalls until both buffer slots and the input word are taken
  task automatic t_buffer;
    for (int i = 1; i < 4; i++)
      hx(1, 0, 0, 0, 16'(i));
    `CHK(inputFullFlag, 1'b1)
    for (int i = 1; i < 4; i++)
      pull(16'(i));
    repeat (4) @(negedge clk);
    `CHK(inputFullFlag, 1'b0)
    $display("t_buffer done");
  endtask
  initial
  begin
    reset = 1'b1;
    controlLoad = 1'b0;
    controlData = 16'h0000;
    outWordValid = 1'b0;
    outWord = 16'h0000;
    inWordReady = 1'b0;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    t_wide();
    t_flags();
    t_narrow();
    t_strobe();
    t_select();
    t_buffer();
    print_verdict();
  end
endmodule // tb_passive_parallel_host_port
